//--- include/otrtd_map.vh
// Command codes, field positions, defaults and limits of the overtemperature command block
`ifndef OTRTD_MAP_VH
`define OTRTD_MAP_VH

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define OTRTD_CMD_FAULT_THR     8'h4F
`define OTRTD_CMD_FAULT_ACT     8'h50
`define OTRTD_CMD_WARN_THR      8'h51
`define OTRTD_CMD_TON_WAIT      8'h60
`define OTRTD_CMD_VENDOR_CFG    8'hF5
`define OTRTD_CMD_STATUS_BYTE   8'h78
`define OTRTD_CMD_STATUS_TEMP   8'h7D
`define OTRTD_CMD_STATUS_COMM   8'h7E

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define OTRTD_ACT_IGNORE_BIT    7
`define OTRTD_ACT_RETRY_BIT     5
`define OTRTD_VCFG_OVERRIDE_BIT 4
`define OTRTD_SB_TEMP_BIT       2
`define OTRTD_SB_COMM_BIT       1
`define OTRTD_ST_FAULT_BIT      7
`define OTRTD_ST_WARN_BIT       6
`define OTRTD_SC_INVCMD_BIT     7
`define OTRTD_SC_INVDATA_BIT    6

// ----------------------------------------------------------------
// Defaults, limits, timing
// ----------------------------------------------------------------
`define OTRTD_ACT_RESET         8'h3F
`define OTRTD_WARN_RESET        11'h078
`define OTRTD_WARN_MIN          11'h064
`define OTRTD_WARN_MAX          11'h08C
`define OTRTD_WARN_OFFSET       11'h019
`define OTRTD_FAULT_RESET       11'h091
`define OTRTD_TON_RESET         7'h00
`define OTRTD_HYST_DEG          11'h014
`define OTRTD_RETRY_RISES       3'h7
`define OTRTD_MS_NS             1000000
`define OTRTD_CLK_NS            100
`define OTRTD_MS_CYCLES         (`OTRTD_MS_NS / `OTRTD_CLK_NS)

`endif

//--- logic/otrtd_core.v
// Overtemperature response, warning threshold and turn-on wait command logic
// Summary of operation
// - Ignore bit 0: keep regulating, still set fault status and alert.
// - Ignore bit 1: shut output down, then follow retry setting.
// - Retry 000: no restart, output stays off until fault cleared.
// - Retry 111: restart by soft start endlessly until off or other fault.
// - Retry write other than 000/111 rejected; comm fault, invalid data, alert.
// - Only bits 7 and 5 of the action field are stored; bit 6 reads zero, bits 4:0 rebuilt from bit 5.
// - Bandgap overtemperature never ignored: shutdown, restart once cooled unless a fault with ignore bit 1 and retry 000 is also active.
// - Retry delay 000: no delay, only with retry 000, output stays off.
// - Retry delay 111: wait seven ramp periods before each restart.
// - Retry delay bits read back as copies of bit 5.
// - Retry and retry delay settings default to 111 after reset; restore loads the stored setting.
// - Temperature above warning threshold: status bits set, alert raised.
// - Warning flag holds until temperature is 20 degrees below threshold.
// - Warning write at or above fault threshold refused; comm fault, alert.
// - Override bit 4 of vendor config skips the warning limit check.
// - Restore sets warning to stored fault threshold minus 25, min 100.
// - Warning word exponent zero; mantissa default 120, range 100 to 140 (range not checked on write).
// - Turn-on wait in ms from start to ramp, default zero.
// - Loop slave: turn-on wait inaccessible, NACK, invalid command, alert.
// - Turn-on wait saved to storage on store-all command.
// - Overtemperature fault sets summary and temperature bits, raises alert.
// - Fault flag holds until temperature is 20 degrees below fault threshold.
`default_nettype none
`include "otrtd_map.vh"
module otrtd_core (
    input  wire        sys_clk,
    input  wire        rst_n,
    input  wire        cmd_wr,
    input  wire        cmd_rd,
    input  wire [7:0]  cmd_code,
    input  wire [15:0] cmd_wdata,
    output reg  [15:0] cmd_rdata,
    output reg         cmd_nack,
    input  wire        clear_faults,
    input  wire        store_all,
    input  wire        restore_all,
    input  wire        loop_slave,
    input  wire        start_req,
    input  wire        stop_req,
    input  wire [10:0] ext_temp,
    input  wire        bandgap_ot,
    input  wire [6:0]  ramp_time_ms,
    output reg         output_enable,
    output reg         ramp_start,
    output wire        alert_n
);
    // ----------------------------------------------------------------
    // Registers and synchronisers
    // ----------------------------------------------------------------
    reg        ignore_select_bit, retry_bit;
    reg [10:0] warning_threshold_value;
    reg [10:0] fault_threshold_value;
    reg [6:0]  turn_on_wait_time;
    reg [7:0]  vendor_config_reg;
    reg        warn_flag, fault_flag, bg_flag;
    reg        comm_fault_flag, inv_data_flag, invalid_command_flag;
    reg [10:0] temp_s1, temp_s2;
    reg        bg_s1, bg_s2;
    reg        restore_pend, nvm_wr;
    reg [1:0]  nvm_step, nvm_waddr, nvm_raddr;
    reg [10:0] nvm_wdata;
    wire [10:0] nvm_rdata;
    reg [2:0]  state, rise_cnt;
    reg [13:0] ms_cnt;
    reg [6:0]  ms_left;
    reg        ms_tick;

    localparam [2:0] ST_OFF   = 3'h0;
    localparam [2:0] ST_WAIT  = 3'h1;
    localparam [2:0] ST_ON    = 3'h2;
    localparam [2:0] ST_LATCH = 3'h3;
    localparam [2:0] ST_RETRY = 3'h4;
    localparam [31:0] MS_ALL  = `OTRTD_MS_CYCLES - 1;
    localparam [13:0] MS_LAST = MS_ALL[13:0];

    // Limit check shared by write path and flag clearing
    function above_by;
        input [10:0] a;
        input [10:0] b;
        begin
            above_by = (a > b);
        end
    endfunction

    wire wr_act   = cmd_wr && cmd_code == `OTRTD_CMD_FAULT_ACT;
    wire wr_warn  = cmd_wr && cmd_code == `OTRTD_CMD_WARN_THR;
    wire wr_fault = cmd_wr && cmd_code == `OTRTD_CMD_FAULT_THR;
    wire acc_ton  = (cmd_wr || cmd_rd) && cmd_code == `OTRTD_CMD_TON_WAIT;
    wire ton_blk  = acc_ton && loop_slave;
    wire rs_ok    = cmd_wdata[5:3] == 3'h0 || cmd_wdata[5:3] == 3'h7;
    wire bad_act  = wr_act && !rs_ok;
    wire warn_ok  = vendor_config_reg[`OTRTD_VCFG_OVERRIDE_BIT] ||
                    above_by(fault_threshold_value, cmd_wdata[10:0]);
    wire bad_warn = wr_warn && !warn_ok;
    wire bad_flt  = wr_fault && !above_by(cmd_wdata[10:0], warning_threshold_value);
    wire bad_data = bad_act || bad_warn || bad_flt;
    wire fault_hit = above_by(temp_s2, fault_threshold_value);
    wire fault_rel = !above_by(temp_s2 + `OTRTD_HYST_DEG, fault_threshold_value);
    wire warn_rel  = !above_by(temp_s2 + `OTRTD_HYST_DEG, warning_threshold_value);
    wire [10:0] warn_def = (fault_threshold_value - `OTRTD_WARN_OFFSET < `OTRTD_WARN_MIN) ?
                           `OTRTD_WARN_MIN : fault_threshold_value - `OTRTD_WARN_OFFSET;
    wire shut_cause = (fault_flag && ignore_select_bit) || bg_flag;
    wire warn_hit   = above_by(temp_s2, warning_threshold_value);
    wire [7:0] act_rst = `OTRTD_ACT_RESET;

    // ----------------------------------------------------------------
    // Storage image
    // ----------------------------------------------------------------
    otrtd_nvm u_nvm (
        .sys_clk (sys_clk),
        .wr_en   (nvm_wr),
        .wr_addr (nvm_waddr),
        .wr_data (nvm_wdata),
        .rd_addr (nvm_raddr),
        .rd_data (nvm_rdata)
    );

    // ----------------------------------------------------------------
    // Command registers, store and restore
    // ----------------------------------------------------------------
    always @(posedge sys_clk) begin
        temp_s1 <= ext_temp;
        temp_s2 <= temp_s1;
        bg_s1   <= bandgap_ot;
        bg_s2   <= bg_s1;
        nvm_wr  <= 1'b0;
        if (!rst_n) begin
            ignore_select_bit       <= act_rst[`OTRTD_ACT_IGNORE_BIT];
            retry_bit               <= act_rst[`OTRTD_ACT_RETRY_BIT];
            warning_threshold_value <= `OTRTD_WARN_RESET;
            fault_threshold_value   <= `OTRTD_FAULT_RESET;
            turn_on_wait_time       <= `OTRTD_TON_RESET;
            vendor_config_reg       <= 8'h00;
            // Image is blank until the first store, so reset takes built-in defaults
            restore_pend            <= 1'b0;
            nvm_step                <= 2'h0;
            nvm_raddr               <= 2'h0;
            nvm_waddr               <= 2'h0;
            nvm_wdata               <= 11'h000;
        end else if (store_all) begin
            nvm_step <= 2'h1;
            nvm_wr   <= 1'b1;
            nvm_waddr <= 2'h0;
            nvm_wdata <= {8'h00, ignore_select_bit, retry_bit, 1'b0};
        end else if (nvm_step != 2'h0 && !restore_pend) begin
            nvm_wr    <= 1'b1;
            nvm_waddr <= nvm_step;
            nvm_wdata <= (nvm_step == 2'h1) ? fault_threshold_value :
                         {4'h0, turn_on_wait_time};
            nvm_step  <= (nvm_step == 2'h2) ? 2'h0 : nvm_step + 2'h1;
        end else if (restore_all && !restore_pend) begin
            restore_pend <= 1'b1;
            nvm_step     <= 2'h0;
            nvm_raddr    <= 2'h0;
        end else if (restore_pend) begin
            // Read data lag one cycle behind the address
            nvm_step  <= nvm_step + 2'h1;
            nvm_raddr <= nvm_raddr + 2'h1;
            case (nvm_step)
                2'h1: begin
                    ignore_select_bit <= nvm_rdata[2];
                    retry_bit         <= nvm_rdata[1];
                end
                2'h2: fault_threshold_value <= nvm_rdata;
                2'h3: begin
                    turn_on_wait_time <= nvm_rdata[6:0];
                    warning_threshold_value <= warn_def;
                    restore_pend      <= 1'b0;
                    nvm_step          <= 2'h0;
                end
                default: ;
            endcase
        end else begin
            if (wr_act && rs_ok) begin
                ignore_select_bit <= cmd_wdata[`OTRTD_ACT_IGNORE_BIT];
                retry_bit         <= cmd_wdata[`OTRTD_ACT_RETRY_BIT];
            end
            if (wr_warn && warn_ok) begin
                warning_threshold_value <= cmd_wdata[10:0];
            end
            if (wr_fault && !bad_flt) begin
                fault_threshold_value <= cmd_wdata[10:0];
            end
            if (cmd_wr && cmd_code == `OTRTD_CMD_TON_WAIT && !loop_slave) begin
                turn_on_wait_time <= cmd_wdata[6:0];
            end
            if (cmd_wr && cmd_code == `OTRTD_CMD_VENDOR_CFG) begin
                vendor_config_reg <= cmd_wdata[7:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Status flags: set wins over clear
    // ----------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            warn_flag            <= 1'b0;
            fault_flag           <= 1'b0;
            bg_flag              <= 1'b0;
            comm_fault_flag      <= 1'b0;
            inv_data_flag        <= 1'b0;
            invalid_command_flag <= 1'b0;
        end else begin
            // Warning and fault temperature flags release only by hysteresis, never by clear
            warn_flag            <= warn_hit || (warn_flag && !warn_rel);
            fault_flag           <= fault_hit || (fault_flag && !fault_rel);
            bg_flag              <= bg_s2 || (bg_flag && state != ST_RETRY && !clear_faults);
            comm_fault_flag      <= bad_data || ton_blk ||
                                    (comm_fault_flag && !clear_faults);
            inv_data_flag        <= bad_data || (inv_data_flag && !clear_faults);
            invalid_command_flag <= ton_blk || (invalid_command_flag && !clear_faults);
        end
    end

    assign alert_n = !(warn_flag || fault_flag || bg_flag || comm_fault_flag);

    // ----------------------------------------------------------------
    // Millisecond tick
    // ----------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (!rst_n || state == ST_OFF || state == ST_ON || state == ST_LATCH) begin
            ms_cnt  <= 14'h0000;
            ms_tick <= 1'b0;
        end else begin
            ms_tick <= ms_cnt == MS_LAST;
            ms_cnt  <= (ms_cnt == MS_LAST) ? 14'h0000 : ms_cnt + 14'h0001;
        end
    end

    // ----------------------------------------------------------------
    // Output sequencer
    // ----------------------------------------------------------------
    always @(posedge sys_clk) begin
        ramp_start <= 1'b0;
        if (!rst_n) begin
            state         <= ST_OFF;
            output_enable <= 1'b0;
            ms_left       <= 7'h00;
            rise_cnt      <= 3'h0;
        end else begin
            case (state)
                ST_OFF: begin
                    if (start_req) begin
                        state   <= ST_WAIT;
                        ms_left <= turn_on_wait_time;
                    end
                end
                ST_WAIT: begin
                    if (stop_req) begin
                        state <= ST_OFF;
                    end else if (ms_left == 7'h00) begin
                        state         <= ST_ON;
                        output_enable <= 1'b1;
                        ramp_start    <= 1'b1;
                    end else if (ms_tick) begin
                        ms_left <= ms_left - 7'h01;
                    end
                end
                ST_ON: begin
                    if (stop_req) begin
                        state         <= ST_OFF;
                        output_enable <= 1'b0;
                    end else if (shut_cause) begin
                        output_enable <= 1'b0;
                        // Bandgap trip restarts whatever the retry bit, unless the retry bit is 0 and a fault with ignore bit 1 is also active
                        if (retry_bit || (bg_flag && !(fault_flag && ignore_select_bit))) begin
                            state    <= ST_RETRY;
                            rise_cnt <= `OTRTD_RETRY_RISES;
                            ms_left  <= ramp_time_ms;
                        end else begin
                            state <= ST_LATCH;
                        end
                    end
                end
                ST_LATCH: begin
                    if (clear_faults && !fault_hit) begin
                        state <= ST_OFF;
                    end
                end
                ST_RETRY: begin
                    if (stop_req) begin
                        state <= ST_OFF;
                    end else if (ms_left == 7'h00) begin
                        if (rise_cnt == 3'h1 || rise_cnt == 3'h0) begin
                            state         <= ST_ON;
                            output_enable <= 1'b1;
                            ramp_start    <= 1'b1;
                        end else begin
                            rise_cnt <= rise_cnt - 3'h1;
                            ms_left  <= ramp_time_ms;
                        end
                    end else if (ms_tick) begin
                        ms_left <= ms_left - 7'h01;
                    end
                end
                default: state <= ST_OFF;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            cmd_rdata <= 16'h0000;
            cmd_nack  <= 1'b0;
        end else begin
            cmd_nack <= ton_blk;
            if (cmd_rd) begin
                case (cmd_code)
                    `OTRTD_CMD_FAULT_ACT:
                        cmd_rdata <= {8'h00, ignore_select_bit, 1'b0,
                                      {3{retry_bit}}, {3{retry_bit}}};
                    `OTRTD_CMD_WARN_THR:  cmd_rdata <= {5'h00, warning_threshold_value};
                    `OTRTD_CMD_FAULT_THR: cmd_rdata <= {5'h00, fault_threshold_value};
                    `OTRTD_CMD_TON_WAIT:
                        cmd_rdata <= loop_slave ? 16'h0000 : {9'h000, turn_on_wait_time};
                    `OTRTD_CMD_VENDOR_CFG: cmd_rdata <= {8'h00, vendor_config_reg};
                    `OTRTD_CMD_STATUS_BYTE:
                        cmd_rdata <= {8'h00, 5'h00, warn_flag || fault_flag || bg_flag,
                                      comm_fault_flag, 1'b0};
                    `OTRTD_CMD_STATUS_TEMP:
                        cmd_rdata <= {8'h00, fault_flag || bg_flag, warn_flag, 6'h00};
                    `OTRTD_CMD_STATUS_COMM:
                        cmd_rdata <= {8'h00, invalid_command_flag, inv_data_flag, 6'h00};
                    default: cmd_rdata <= 16'h0000;
                endcase
            end
        end
    end
endmodule // otrtd_core
`default_nettype wire

//--- logic/otrtd_nvm.v
// Small nonvolatile backing store, register-read, for stored command defaults
`default_nettype none
module otrtd_nvm (
    input  wire        sys_clk,
    input  wire        wr_en,
    input  wire [1:0]  wr_addr,
    input  wire [10:0] wr_data,
    input  wire [1:0]  rd_addr,
    output reg  [10:0] rd_data
);
    // ----------------------------------------------------------------
    // Storage, no reset: contents survive resets as a stored image would
    // ----------------------------------------------------------------
    reg [10:0] mem [0:3];

    always @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule // otrtd_nvm
`default_nettype wire

//--- test/otrtd_asserts.sv
// Concurrent checks on the overtemperature command block ports
`default_nettype none
`include "otrtd_map.vh"
module otrtd_asserts (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        cmd_wr,
    input wire logic        cmd_rd,
    input wire logic [7:0]  cmd_code,
    input wire logic [15:0] cmd_wdata,
    input wire logic [15:0] cmd_rdata,
    input wire logic        cmd_nack,
    input wire logic        store_all,
    input wire logic        restore_all,
    input wire logic        loop_slave,
    input wire logic        bandgap_ot,
    input wire logic        output_enable,
    input wire logic        ramp_start,
    input wire logic        alert_n
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire ls_acc = (cmd_wr | cmd_rd) && cmd_code == `OTRTD_CMD_TON_WAIT && loop_slave;
    wire ok_rs  = cmd_wdata[5:3] == 3'h0 || cmd_wdata[5:3] == 3'h7;
    sequence act_wr_ok;
        cmd_wr && cmd_code == `OTRTD_CMD_FAULT_ACT && ok_rs && !store_all && !restore_all;
    endsequence
    sequence act_rd;
        cmd_rd && cmd_code == `OTRTD_CMD_FAULT_ACT;
    endsequence
    act_echo_a: assert property (act_wr_ok ##2 act_rd |=>
        cmd_rdata[7:0] == {$past(cmd_wdata[7], 3), 1'b0, {6{$past(cmd_wdata[5], 3)}}})
        else $error("action readback wrong");
    bad_retry_a: assert property (cmd_wr && cmd_code == `OTRTD_CMD_FAULT_ACT && !ok_rs
        |-> ##[1:3] !alert_n) else $error("bad retry not alerted");
    nack_cause_a: assert property (cmd_nack |-> $past(ls_acc))
        else $error("nack without cause");
    nack_given_a: assert property (ls_acc |=> cmd_nack)
        else $error("loop slave access not nacked");
    nack_alert_a: assert property (cmd_nack |-> ##[0:2] !alert_n)
        else $error("nack without alert");
    rdata_hold_a: assert property (!$past(cmd_rd) && $past(rst_n) |-> $stable(cmd_rdata))
        else $error("read data moved");
    bandgap_off_a: assert property (bandgap_ot [*4] |-> ##[0:3] !output_enable)
        else $error("bandgap fault kept output on");
    ramp_pulse_a: assert property (ramp_start |=> !ramp_start)
        else $error("ramp start too long");
endmodule // otrtd_asserts
`default_nettype wire

//--- test/otrtd_host.sv
// Bus host model issuing command reads and writes
`default_nettype none
module otrtd_host (
    input  wire logic        sys_clk,
    input  wire logic [15:0] cmd_rdata,
    input  wire logic        cmd_nack,
    output logic             cmd_wr,
    output logic             cmd_rd,
    output logic [7:0]       cmd_code,
    output logic [15:0]      cmd_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        cmd_wr = 1'b0;
        cmd_rd = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 16'h0000;
    end
    // One word per transfer; released data inverted so stale values never match
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                        output logic [15:0] q, output logic nk);
        @(negedge sys_clk);
        cmd_wr = w;
        cmd_rd = !w;
        cmd_code = c;
        cmd_wdata = d;
        @(negedge sys_clk);
        cmd_wr = 1'b0;
        cmd_rd = 1'b0;
        cmd_wdata = ~d;
        nk = cmd_nack;
        if (!w) begin
            @(negedge sys_clk);
        end
        q = cmd_rdata;
    endtask
endmodule // otrtd_host
`default_nettype wire

//--- test/tb_top.sv
// Top testbench for the overtemperature command block
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [4:0]  ev = 5'h00;
    logic        loop_slave = 1'b0;
    logic        bandgap_ot = 1'b0;
    logic [10:0] ext_temp = 11'h019;
    logic [15:0] q;
    logic        nk;
    wire  [15:0] cmd_rdata, cmd_wdata;
    wire  [7:0]  cmd_code;
    wire         cmd_wr, cmd_rd, cmd_nack, output_enable, ramp_start, alert_n;
    int          err_count = 0;
    int          n_checks = 0;
    int          cyc = 0;
    otrtd_core uut (.sys_clk(sys_clk), .rst_n(rst_n), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
        .cmd_nack(cmd_nack), .clear_faults(ev[0]), .store_all(ev[1]),
        .restore_all(ev[2]), .loop_slave(loop_slave), .start_req(ev[3]),
        .stop_req(ev[4]), .ext_temp(ext_temp), .bandgap_ot(bandgap_ot),
        .ramp_time_ms(7'h01), .output_enable(output_enable), .ramp_start(ramp_start),
        .alert_n(alert_n));
    otrtd_host host (.sys_clk(sys_clk), .cmd_rdata(cmd_rdata), .cmd_nack(cmd_nack),
        .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));
    always #50 sys_clk = ~sys_clk;
    // Run needs about 320 cycles; ceiling leaves ample room
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            $display("[ERR] %0t timeout", $time);
            stop_test();
        end
    end
    task chk(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task rc(input logic [7:0] c, input logic [15:0] e);
        host.xfer(1'b0, c, 16'h0000, q, nk);
        chk(q, e);
    endtask
    task rb(input logic [7:0] c, input int b, input logic e);
        host.xfer(1'b0, c, 16'h0000, q, nk);
        chk({15'h0000, q[b]}, {15'h0000, e});
    endtask
    task wr(input logic [7:0] c, input logic [15:0] d);
        host.xfer(1'b1, c, d, q, nk);
    endtask
    task pulse(input int i);
        @(negedge sys_clk);
        ev[i] = 1'b1;
        @(negedge sys_clk);
        ev = 5'h00;
        repeat (6) @(negedge sys_clk);
    endtask
    // Sensor input is synchronised inside, so settle before looking
    task temp(input logic [10:0] t);
        @(negedge sys_clk);
        ext_temp = t;
        repeat (10) @(negedge sys_clk);
    endtask
    task up();
        pulse(3);
        for (int i = 0; i < 3000 && output_enable !== 1'b1; i++) @(negedge sys_clk);
        chk({15'h0000, output_enable}, 16'h0001);
    endtask
    task t_defaults();
        rc(8'h51, 16'h0078);
        rc(8'h50, 16'h003F);
        rc(8'h60, 16'h0000);
    endtask
    task t_action();
        wr(8'h50, 16'h0088);
        rc(8'h50, 16'h003F);
        rb(8'h78, 1, 1'b1);
        rb(8'h7E, 6, 1'b1);
        chk({15'h0000, alert_n}, 16'h0000);
        pulse(0);
        wr(8'h50, 16'h0080);
        rc(8'h50, 16'h0080);
        wr(8'h50, 16'h00B8);
        rc(8'h50, 16'h00BF);
        wr(8'h50, 16'h003F);
    endtask
    task t_warn_lim();
        wr(8'h4F, 16'h0082);
        wr(8'h51, 16'h008C);
        rc(8'h51, 16'h0078);
        rb(8'h7E, 6, 1'b1);
        pulse(0);
        wr(8'hF5, 16'h0010);
        wr(8'h51, 16'h008C);
        rc(8'h51, 16'h008C);
        wr(8'hF5, 16'h0000);
        wr(8'h51, 16'h0078);
        wr(8'h4F, 16'h0091);
        pulse(0);
    endtask
    task t_warn_flag();
        temp(11'h079);
        rb(8'h7D, 6, 1'b1);
        rb(8'h78, 2, 1'b1);
        chk({15'h0000, alert_n}, 16'h0000);
        temp(11'h065);
        pulse(0);
        rb(8'h7D, 6, 1'b1);
        temp(11'h063);
        pulse(0);
        rb(8'h7D, 6, 1'b0);
    endtask
    task t_fault();
        up();
        temp(11'h096);
        chk({15'h0000, output_enable}, 16'h0001);
        rb(8'h7D, 7, 1'b1);
        temp(11'h082);
        pulse(0);
        rb(8'h7D, 7, 1'b1);
        temp(11'h019);
        pulse(0);
        rb(8'h7D, 7, 1'b0);
        wr(8'h50, 16'h0080);
        temp(11'h096);
        chk({15'h0000, output_enable}, 16'h0000);
        temp(11'h019);
        chk({15'h0000, output_enable}, 16'h0000);
        pulse(0);
        wr(8'h50, 16'h003F);
        up();
        @(negedge sys_clk);
        bandgap_ot = 1'b1;
        repeat (10) @(negedge sys_clk);
        chk({15'h0000, output_enable}, 16'h0000);
        bandgap_ot = 1'b0;
    endtask
    task t_store_loop();
        wr(8'h60, 16'h0005);
        wr(8'h50, 16'h0080);
        pulse(1);
        wr(8'h60, 16'h0009);
        wr(8'h50, 16'h00BF);
        wr(8'h51, 16'h0070);
        pulse(2);
        rc(8'h60, 16'h0005);
        rc(8'h50, 16'h0080);
        rc(8'h51, 16'h0078);
        @(negedge sys_clk);
        loop_slave = 1'b1;
        wr(8'h60, 16'h0007);
        chk({15'h0000, nk}, 16'h0001);
        host.xfer(1'b0, 8'h60, 16'h0000, q, nk);
        chk({15'h0000, nk}, 16'h0001);
        rb(8'h7E, 7, 1'b1);
        loop_slave = 1'b0;
        rc(8'h60, 16'h0005);
    endtask
    task stop_test();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (6) @(negedge sys_clk);
        t_defaults();
        t_action();
        t_warn_lim();
        t_warn_flag();
        t_fault();
        t_store_loop();
        stop_test();
    end
endmodule // tb_top
bind otrtd_core otrtd_asserts chk_i (.sys_clk(sys_clk), .rst_n(rst_n), .cmd_wr(cmd_wr),
    .cmd_rd(cmd_rd), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
    .cmd_nack(cmd_nack), .store_all(store_all), .restore_all(restore_all),
    .loop_slave(loop_slave), .bandgap_ot(bandgap_ot), .output_enable(output_enable),
    .ramp_start(ramp_start), .alert_n(alert_n));
`default_nettype wire
